// ===== common/coc_pkg.sv
// Constants, field layout and types shared by the compare output control block.
package coc_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 2;
  localparam logic [AW-1:0] ADDR_CTRL = 2'h0;
  localparam logic [AW-1:0] ADDR_STAT = 2'h1;
  localparam logic [AW-1:0] ADDR_MASK = 2'h2;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int unsigned BIT_HOLD  = 15;
  localparam int unsigned BIT_FLVL  = 14;
  localparam int unsigned BIT_FORCE = 13;
  localparam int unsigned BIT_INV   = 12;
  localparam int unsigned FW_LSB    = 9;
  localparam int unsigned FW_W      = 2;
  localparam int unsigned BIT_CASC  = 8;
  localparam int unsigned BIT_TRIG  = 7;
  localparam int unsigned BIT_TSTAT = 6;
  localparam int unsigned BIT_TRIS  = 5;
  localparam int unsigned SRC_LSB   = 0;
  localparam int unsigned SRC_W     = 5;
  localparam int unsigned NSRC      = 32;
  localparam logic [DW-1:0] CTRL_RESET = 16'h000C;
  localparam logic [DW-1:0] CTRL_WMASK = 16'hF7BF;

  // ****************************************
  // Compare mode and fine timing
  // ****************************************
  localparam int unsigned MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_NO_FINE = 3'h1;
  localparam int unsigned QUARTERS = 4;

  // ****************************************
  // Event status bits
  // ****************************************
  localparam int unsigned EV_W     = 3;
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_TRIG  = 1;
  localparam int unsigned EV_HIT   = 2;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;

  typedef enum logic {
    FLT_CLEAR  = 1'b0,
    FLT_ACTIVE = 1'b1
  } coc_fault_t;

endpackage

// ===== common/coc_wave_if.sv
// Carrier between the control logic and the edge shaping stage.
interface coc_wave_if;
  logic                             wave;
  logic                             inv;
  logic                             fault;
  logic                             flvl;
  logic [coc_pkg::FW_W-1:0]         delay;
  logic [coc_pkg::QUARTERS-1:0]     phase;
  modport drive (output wave, output inv, output fault, output flvl, output delay, input phase);
  modport shape (input wave, input inv, input fault, input flvl, input delay, output phase);
endinterface

// ===== src/coc_edge_delay.sv
// Quarter-cycle edge shaping of the compare waveform with invert and fault override.
module coc_edge_delay (
  input wire logic    clk,
  input wire logic    reset_n,
  input wire logic    clk_en,
  coc_wave_if.shape   w
);
  import coc_pkg::*;

  logic                prev_wave_reg;
  logic                prev_wave_next;
  logic                prev_lvl_reg;
  logic                prev_lvl_next;
  logic [QUARTERS-1:0] phase_reg;
  logic [QUARTERS-1:0] phase_next;
  logic                level;
  logic                fall;

  // ****************************************
  // Next phase pattern
  // ****************************************
  always_comb begin
    level          = w.wave ^ w.inv; // see RULE5
    fall           = prev_wave_reg & ~w.wave;
    prev_wave_next = prev_wave_reg;
    prev_lvl_next  = prev_lvl_reg;
    phase_next     = phase_reg;
    if (clk_en) begin
      prev_wave_next = w.wave;
      prev_lvl_next  = level;
      for (int k = 0; k < QUARTERS; k++) begin
        // The wave's falling transition is held back; inverted, that is the rising edge.
        if (fall && (k < int'(w.delay))) begin // see RULE6 see RULE7
          phase_next[k] = prev_lvl_reg;
        end else begin
          phase_next[k] = level;
        end
      end
      if (w.fault) begin
        phase_next = {QUARTERS{w.flvl}}; // see RULE3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_wave_reg <= 1'b0;
      prev_lvl_reg  <= 1'b0;
      phase_reg     <= '0;
    end else begin
      prev_wave_reg <= prev_wave_next;
      prev_lvl_reg  <= prev_lvl_next;
      phase_reg     <= phase_next;
    end
  end

  assign w.phase = phase_reg;

  // ****************************************
  // Checks
  // ****************************************
  chk_invert_level: assert property (@(posedge clk) disable iff (!reset_n) // see RULE5
    clk_en && !w.fault |=> phase_reg[QUARTERS-1] == $past(level))
    else $error("output level does not follow wave and invert");

  chk_half_delay: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    clk_en && !w.fault && fall && w.delay == 2'h2
    |=> phase_reg[1:0] == {2{$past(prev_lvl_reg)}} && phase_reg[3:2] == {2{$past(level)}})
    else $error("half cycle edge delay wrong");

  chk_three_qtr: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    clk_en && !w.fault && fall && w.delay == 2'h3
    |=> phase_reg[2:0] == {3{$past(prev_lvl_reg)}} && phase_reg[3] == $past(level))
    else $error("three quarter edge delay wrong");

endmodule

// ===== src/coc_compare_output_control.sv
// Output compare second control stage: fault, invert, fine edge, cascade, trigger and pin direction.
//
// Summary of operation
// RULE1: With hold selected, fault persists until input gone and software clears flag.
// RULE2: Without hold, fault ends once input gone and a new period starts.
// RULE3: During fault the output is driven to the fault drive level.
// RULE4: Pin forcing set makes a fault turn the pin to output; else unchanged.
// RULE5: Invert set presents the inverse of the generated waveform.
// RULE6: Fine width code delays falling edge by one, two or three quarters.
// RULE7: Inverted, delay moves to rising edge; no delay in compare mode 001.
// RULE8: Cascade joins both channels into one 32-bit compare; clear keeps them apart.
// RULE9: Trigger select starts on the chosen source, otherwise synchronises to it.
// RULE10: Status flag set when triggered and running, zero while held; software writable.
// RULE11: Tristate bit set floats the pin, clear lets the channel drive it.
// RULE12: Software never makes a channel its own trigger source.
// RULE13: Trigger-only inputs are never chosen as synchronisation sources.
// RULE14: Fault input is sampled on the clock; its effect lands within one clock.
//
// Decided for this implementation: the strobed register port and the register addresses.
module coc_compare_output_control (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         clk_en,
  input  wire logic [coc_pkg::AW-1:0]       reg_addr,
  input  wire logic [coc_pkg::DW-1:0]       reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [coc_pkg::DW-1:0]       reg_rdata,
  input  wire logic                         wave_in,
  input  wire logic [coc_pkg::MODE_W-1:0]   compare_mode,
  input  wire logic                         period_start,
  input  wire logic                         fault_in,
  input  wire logic                         match_lo,
  input  wire logic                         match_hi,
  input  wire logic [coc_pkg::NSRC-1:0]     src_events,
  output logic      [coc_pkg::QUARTERS-1:0] pin_phase,
  output logic                              pin_oe_n,
  output logic                              timer_run,
  output logic                              sync_pulse,
  output logic                              hit_lo,
  output logic                              hit_hi,
  output logic                              cascade_on,
  output logic                              irq
);
  import coc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [DW-1:0]    ctrl_reg;
  logic [DW-1:0]    ctrl_next;
  logic             tstat_reg;
  logic             tstat_next;
  logic [EV_W-1:0]  stat_reg;
  logic [EV_W-1:0]  stat_next;
  logic [EV_W-1:0]  mask_reg;
  logic [EV_W-1:0]  mask_next;
  logic [DW-1:0]    rdata_reg;
  logic [DW-1:0]    rdata_next;
  coc_fault_t       fault_reg;
  coc_fault_t       fault_next;
  logic             oe_n_reg;
  logic             oe_n_next;
  logic             run_reg;
  logic             run_next;
  logic             sync_reg;
  logic             sync_next;
  logic             hit_lo_reg;
  logic             hit_lo_next;
  logic             hit_hi_reg;
  logic             hit_hi_next;
  logic             irq_reg;
  logic             irq_next;

  // ****************************************
  // Decoded fields and events
  // ****************************************
  logic             hold_sel;
  logic             flvl;
  logic             force_out;
  logic             inv;
  logic [FW_W-1:0]  fine;
  logic             casc;
  logic             trig_sel;
  logic             tris;
  logic [SRC_W-1:0] src;
  logic             sel_event;
  logic             fault_now;
  logic [EV_W-1:0]  ev_set;
  logic [DW-1:0]    ctrl_rd;

  always_comb begin
    hold_sel  = ctrl_reg[BIT_HOLD];
    flvl      = ctrl_reg[BIT_FLVL];
    force_out = ctrl_reg[BIT_FORCE];
    inv       = ctrl_reg[BIT_INV];
    fine      = ctrl_reg[FW_LSB +: FW_W];
    casc      = ctrl_reg[BIT_CASC];
    trig_sel  = ctrl_reg[BIT_TRIG];
    tris      = ctrl_reg[BIT_TRIS];
    src       = ctrl_reg[SRC_LSB +: SRC_W];
    // Software is expected to keep the channel itself and trigger-only inputs out of sync use.
    sel_event = src_events[src]; // see RULE12 see RULE13
    ctrl_rd            = ctrl_reg;
    ctrl_rd[BIT_TSTAT] = tstat_reg;
  end

  // ****************************************
  // Fault state machine
  // ****************************************
  always_comb begin
    fault_next = fault_reg;
    if (clk_en) begin
      case (fault_reg)
        FLT_CLEAR: begin
          if (fault_in) begin // see RULE14
            fault_next = FLT_ACTIVE;
          end
        end
        FLT_ACTIVE: begin
          if (!fault_in) begin
            if (hold_sel) begin
              if (!stat_reg[EV_FAULT]) begin // see RULE1
                fault_next = FLT_CLEAR;
              end
            end else if (period_start) begin // see RULE2
              fault_next = FLT_CLEAR;
            end
          end
        end
        default: begin
          fault_next = FLT_CLEAR;
        end
      endcase
    end
  end

  // The shaping stage sees the fault in the same cycle it is sampled.
  always_comb begin
    fault_now = (fault_next == FLT_ACTIVE);
  end

  always_comb begin
    ev_set           = '0;
    ev_set[EV_FAULT] = fault_in;
    ev_set[EV_TRIG]  = trig_sel & sel_event & ~tstat_reg;
    ev_set[EV_HIT]   = hit_lo_next;
  end

  // ****************************************
  // Register port and event status
  // ****************************************
  always_comb begin
    ctrl_next  = ctrl_reg;
    tstat_next = tstat_reg;
    stat_next  = stat_reg;
    mask_next  = mask_reg;
    rdata_next = rdata_reg;
    if (clk_en) begin
      rdata_next = '0;
      if (reg_wr && reg_addr == ADDR_CTRL) begin
        ctrl_next  = reg_wdata & CTRL_WMASK;
        tstat_next = reg_wdata[BIT_TSTAT]; // see RULE10
      end
      if (reg_wr && reg_addr == ADDR_STAT) begin
        stat_next = stat_reg & ~reg_wdata[EV_W-1:0];
      end
      if (reg_wr && reg_addr == ADDR_MASK) begin
        mask_next = reg_wdata[EV_W-1:0];
      end
      // A hardware set in the clearing cycle wins.
      stat_next = stat_next | ev_set;
      // A trigger in the cycle that software clears the flag still starts the timer.
      if (trig_sel && sel_event) begin
        tstat_next = 1'b1; // see RULE10
      end
      if (reg_rd) begin
        case (reg_addr)
          ADDR_CTRL: begin
            rdata_next = ctrl_rd;
          end
          ADDR_STAT: begin
            rdata_next = DW'(stat_reg);
          end
          ADDR_MASK: begin
            rdata_next = DW'(mask_reg);
          end
          default: begin
            rdata_next = '0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Timer start, cascade, pin and interrupt
  // ****************************************
  always_comb begin
    run_next    = run_reg;
    sync_next   = sync_reg;
    hit_lo_next = hit_lo_reg;
    hit_hi_next = hit_hi_reg;
    oe_n_next   = oe_n_reg;
    irq_next    = irq_reg;
    if (clk_en) begin
      // Trigger mode holds the timer clear until the flag is set; sync mode restarts it.
      run_next    = trig_sel ? tstat_next : 1'b1; // see RULE9
      sync_next   = ~trig_sel & sel_event; // see RULE9
      hit_lo_next = casc ? (match_lo & match_hi) : match_lo; // see RULE8
      hit_hi_next = casc ? 1'b0 : match_hi; // see RULE8
      oe_n_next   = tris & ~(fault_now & force_out); // see RULE4 see RULE11
      irq_next    = |(stat_next & mask_next);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg   <= CTRL_RESET;
      tstat_reg  <= 1'b0;
      stat_reg   <= EV_RESET;
      mask_reg   <= EV_RESET;
      rdata_reg  <= '0;
      fault_reg  <= FLT_CLEAR;
      oe_n_reg   <= 1'b0;
      run_reg    <= 1'b1;
      sync_reg   <= 1'b0;
      hit_lo_reg <= 1'b0;
      hit_hi_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      tstat_reg  <= tstat_next;
      stat_reg   <= stat_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
      fault_reg  <= fault_next;
      oe_n_reg   <= oe_n_next;
      run_reg    <= run_next;
      sync_reg   <= sync_next;
      hit_lo_reg <= hit_lo_next;
      hit_hi_reg <= hit_hi_next;
      irq_reg    <= irq_next;
    end
  end

  // ****************************************
  // Edge shaping stage
  // ****************************************
  coc_wave_if wif ();

  always_comb begin
    wif.wave  = wave_in;
    wif.inv   = inv; // see RULE5
    wif.fault = fault_now; // see RULE3
    wif.flvl  = flvl;
    wif.delay = (compare_mode == MODE_NO_FINE) ? '0 : fine; // see RULE7
  end

  coc_edge_delay u_edge (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .w       (wif.shape)
  );

  assign pin_phase  = wif.phase;
  assign reg_rdata  = rdata_reg;
  assign pin_oe_n   = oe_n_reg;
  assign timer_run  = run_reg;
  assign sync_pulse = sync_reg;
  assign hit_lo     = hit_lo_reg;
  assign hit_hi     = hit_hi_reg;
  assign cascade_on = ctrl_reg[BIT_CASC];
  assign irq        = irq_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_hold_stays: assert property ( // see RULE1
    clk_en && fault_reg == FLT_ACTIVE && hold_sel && stat_reg[EV_FAULT] |=> fault_reg == FLT_ACTIVE)
    else $error("held fault left before flag clear");

  chk_auto_exit: assert property ( // see RULE2
    clk_en && fault_reg == FLT_ACTIVE && !hold_sel && !fault_in && period_start |=> fault_reg == FLT_CLEAR)
    else $error("fault not left at new period");

  chk_fault_drive: assert property ( // see RULE3 see RULE14
    clk_en && fault_in |=> pin_phase == {QUARTERS{$past(flvl)}})
    else $error("fault level not on output one clock after fault");

  chk_pin_force: assert property ( // see RULE4
    clk_en && fault_in && force_out |=> !pin_oe_n)
    else $error("fault did not force pin to output");

  chk_pin_tristate: assert property ( // see RULE11
    clk_en && !fault_now && !fault_reg && tris ##1 clk_en && !fault_now && $stable(tris) |=> pin_oe_n[*1])
    else $error("tristate pin driven");

  chk_mode_nofine: assert property ( // see RULE7
    clk_en && compare_mode == MODE_NO_FINE |=> pin_phase == 4'h0 || pin_phase == 4'hF)
    else $error("fine delay active in mode without fine delay");

  chk_cascade_and: assert property ( // see RULE8
    clk_en && casc |=> hit_lo == $past(match_lo & match_hi) && !hit_hi)
    else $error("cascaded hit wrong");

  chk_split_hits: assert property ( // see RULE8
    clk_en && !casc |=> hit_lo == $past(match_lo) && hit_hi == $past(match_hi))
    else $error("independent hits wrong");

  chk_trig_start: assert property ( // see RULE9 see RULE10
    clk_en && trig_sel && sel_event |=> timer_run && tstat_reg)
    else $error("trigger did not start timer");

  chk_held_clear: assert property ( // see RULE10
    clk_en && trig_sel && !tstat_reg && !sel_event && !(reg_wr && reg_addr == ADDR_CTRL)
    |=> !timer_run && !tstat_reg)
    else $error("timer runs while not triggered");

  chk_sync_pulse: assert property ( // see RULE9
    clk_en && !trig_sel && sel_event |=> sync_pulse && timer_run)
    else $error("sync event lost");

endmodule

// ===== verif/coc_pin_load.sv
// Load on the compare pin: resolves drive and tristate for each quarter of the cycle.
module coc_pin_load
  import coc_pkg::*;
#(
  parameter logic PULL = 1'b0
) (
  input  wire logic [coc_pkg::QUARTERS-1:0] pin_phase,
  input  wire logic                         pin_oe_n,
  output logic      [coc_pkg::QUARTERS-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // A floating pin settles to the pull level instead of keeping its last value.
  assign pin_level = pin_oe_n ? {QUARTERS{PULL}} : pin_phase;
endmodule

// ===== verif/coc_compare_output_control_bench.sv
// Self-checking bench for the compare output control block.
module coc_compare_output_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import coc_pkg::*;

  logic                clk, reset_n, clk_en, reg_wr, reg_rd, wave_in, period_start, fault_in;
  logic                match_lo, match_hi, pin_oe_n, timer_run, sync_pulse, hit_lo, hit_hi, cascade_on, irq;
  logic [AW-1:0]       reg_addr;
  logic [DW-1:0]       reg_wdata, reg_rdata, rd, w16;
  logic [MODE_W-1:0]   compare_mode, m;
  logic [NSRC-1:0]     src_events;
  logic [QUARTERS-1:0] pin_phase, pin_level;
  logic                w, wp;
  int                  failures, compares, seed, s;

  coc_compare_output_control i_dut (
    .clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wave_in,
    .compare_mode, .period_start, .fault_in, .match_lo, .match_hi, .src_events, .pin_phase,
    .pin_oe_n, .timer_run, .sync_pulse, .hit_lo, .hit_hi, .cascade_on, .irq
  );

  coc_pin_load i_load (.pin_phase(pin_phase), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // Checking and bus helpers
  // ****************************************
  task automatic test_done;
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected pin levels: on a waveform fall the first quarters keep the old level.
  function automatic logic [3:0] exp_phase(logic p, logic c, logic inv, logic [1:0] d, logic [2:0] md);
    logic [3:0] r;
    int         q;
    q = (md == MODE_NO_FINE) ? 0 : int'(d);
    for (int i = 0; i < 4; i++) begin
      r[i] = (p && !c && i < q) ? (p ^ inv) : (c ^ inv);
    end
    return r;
  endfunction

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rdr(input logic [AW-1:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
    @(posedge clk);
  endtask

  task automatic cyc;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pulse(input int n);
    src_events <= NSRC'(1) << n;
    @(posedge clk);
    src_events <= '0;
    @(negedge clk);
  endtask

  task automatic fault_run(input logic hold, input logic lvl, input logic frc);
    wr(ADDR_CTRL, {hold, lvl, frc, 13'h0020});
    wave_in  <= ~lvl;
    fault_in <= 1'b1;
    cyc;
    chk(pin_phase, {4{lvl}});
    chk(pin_oe_n, !frc);
    chk(pin_level, frc ? {4{lvl}} : 4'h0);
    @(posedge clk);
    fault_in <= 1'b0;
    cyc;
    chk(irq, 1'b1);
    chk(pin_phase, {4{lvl}});
    @(posedge clk);
    period_start <= 1'b1;
    @(posedge clk);
    period_start <= 1'b0;
    cyc;
    chk(pin_phase, hold ? {4{lvl}} : {4{~lvl}});
    @(posedge clk);
    wr(ADDR_STAT, 16'h0001);
    cyc;
    cyc;
    chk(pin_phase, {4{~lvl}});
    chk(irq, 1'b0);
    @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    wave_in = 1'b0;
    compare_mode = '0;
    period_start = 1'b0;
    fault_in = 1'b0;
    match_lo = 1'b0;
    match_hi = 1'b0;
    src_events = '0;
    failures = 0;
    compares = 0;
    seed = 79820;
    wp = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    cyc;
    chk(pin_oe_n, 1'b0);
    chk(timer_run, 1'b1);
    chk(irq, 1'b0);
    @(posedge clk);
    rdr(ADDR_CTRL);
    chk(rd, CTRL_RESET);
    rdr(ADDR_STAT);
    chk(rd, 16'h0000);
    rdr(ADDR_MASK);
    chk(rd, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      w16 = 16'($random(seed));
      wr(ADDR_CTRL, w16);
      rdr(ADDR_CTRL);
      chk(rd & ~16'h0040, w16 & CTRL_WMASK & ~16'h0040);
    end
    wr(2'h3, 16'hA5C3);
    rdr(2'h3);
    chk(rd, 16'h0000);
    wr(ADDR_MASK, 16'hFFFF);
    clk_en <= 1'b0;
    @(posedge clk);
    wr(ADDR_MASK, 16'h0000);
    clk_en <= 1'b1;
    rdr(ADDR_MASK);
    chk(rd, 16'h0007);
    wr(ADDR_MASK, 16'h0001);
    @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CTRL, {3'b000, k[2], 1'b0, k[1:0], 9'h000});
      for (int j = 0; j < 12; j++) begin
        w = 1'($random(seed));
        m = (($random(seed) & 3) == 0) ? MODE_NO_FINE : 3'($random(seed));
        wave_in <= w;
        compare_mode <= m;
        cyc;
        if (j > 0) chk(pin_phase, exp_phase(wp, w, k[2], k[1:0], m));
        wp = w;
        @(posedge clk);
      end
    end
    for (int k = 0; k < 8; k++) fault_run(k[2], k[1], k[0]);
    wr(ADDR_MASK, 16'h0000);
    fault_in <= 1'b1;
    @(posedge clk);
    fault_in <= 1'b0;
    cyc;
    chk(irq, 1'b0);
    @(posedge clk);
    rdr(ADDR_STAT);
    chk(rd & 16'h0001, 16'h0001);
    wr(ADDR_STAT, 16'h0007);
    @(posedge clk);
    // Source stays clear of the channel itself and of trigger-only inputs.
    s = ($random(seed) & 15) + 8;
    wr(ADDR_CTRL, 16'h0080 | 16'(s));
    cyc;
    cyc;
    chk(timer_run, 1'b0);
    @(posedge clk);
    pulse(s ^ 1);
    chk(timer_run, 1'b0);
    @(posedge clk);
    pulse(s);
    chk(timer_run, 1'b1);
    chk(sync_pulse, 1'b0);
    @(posedge clk);
    rdr(ADDR_CTRL);
    chk(rd & 16'h0040, 16'h0040);
    rdr(ADDR_STAT);
    chk(rd & 16'h0002, 16'h0002);
    wr(ADDR_CTRL, 16'h0080 | 16'(s));
    cyc;
    cyc;
    chk(timer_run, 1'b0);
    @(posedge clk);
    wr(ADDR_CTRL, 16'(s));
    pulse(s);
    chk(sync_pulse, 1'b1);
    cyc;
    chk(sync_pulse, 1'b0);
    chk(timer_run, 1'b1);
    @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      if (k == 0 || k == 4) wr(ADDR_CTRL, {7'h00, k[2], 8'h00});
      match_lo <= k[0];
      match_hi <= k[1];
      cyc;
      chk(hit_lo, k[2] ? (k[0] & k[1]) : k[0]);
      chk(hit_hi, k[2] ? 1'b0 : k[1]);
      chk(cascade_on, k[2]);
      @(posedge clk);
    end
    rdr(ADDR_STAT);
    chk(rd & 16'h0004, 16'h0004);
    test_done;
  end
endmodule
